// ==== amp_ctrl_pkg.sv ====
// ----------------------------------------------------------------------------
// shared constants for the amplifier serial control slave
// ----------------------------------------------------------------------------
package amp_ctrl_pkg;

  // chip address: fixed prefix, strap bit, write-only direction bit
  localparam logic [5:0] ADDR_PREFIX   = 6'h36;  // 110110
  localparam logic       ADDR_DIR_BIT  = 1'h0;   // always write

  // bit counting within a byte
  localparam int         BYTE_BITS     = 8;
  localparam logic [3:0] BIT_LAST      = 4'h7;   // index of eighth bit
  localparam logic [3:0] BIT_FIRST     = 4'h0;

  // mode byte layout
  localparam int         MODE_TAG_MSB  = 7;
  localparam int         MODE_TAG_LSB  = 5;
  localparam logic [2:0] MODE_TAG      = 3'h0;   // 000 marks a mode byte
  localparam int         HP_CTRL_BIT   = 4;
  localparam int         GAIN_BIT      = 3;      // 1 = external gain
  localparam int         VOL_MODE_BIT  = 2;      // 1 = adjustable volume
  localparam int         MUTE_BIT      = 1;      // 1 = mute on
  localparam int         ACTIVE_BIT    = 0;      // 1 = device active
  localparam int         CTRL_BITS     = 5;
  localparam logic [4:0] CTRL_RESET    = 5'h00;  // shutdown, play, 0 dB

  // positions in the pin synchroniser vector
  localparam int         SYNC_BITS     = 6;
  localparam int         SYNC_SCL      = 5;
  localparam int         SYNC_SDA      = 4;
  localparam int         SYNC_ADDR_SEL = 3;
  localparam int         SYNC_IF_SEL   = 2;
  localparam int         SYNC_BEEP     = 1;
  localparam int         SYNC_HP_DET   = 0;

  // link sequencing states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_ADDR     = 6'h02,
    ST_ADDR_ACK = 6'h04,
    ST_DATA     = 6'h08,
    ST_DATA_ACK = 6'h10,
    ST_IGNORE   = 6'h20
  } link_state_t;

  // full address byte this device answers to
  function automatic logic [7:0] own_address(input logic addrSel);
    own_address = {ADDR_PREFIX, addrSel, ADDR_DIR_BIT};
  endfunction

  // true when a received byte carries the mode tag
  function automatic logic is_mode_byte(input logic [7:0] rxByte);
    is_mode_byte = (rxByte[MODE_TAG_MSB:MODE_TAG_LSB] == MODE_TAG);
  endfunction

endpackage

// ==== link_bit_capture.sv ====
// ----------------------------------------------------------------------------
// serial bit capture on the bus clock
// ----------------------------------------------------------------------------
module link_bit_capture
  import amp_ctrl_pkg::*;
#(
  parameter int WIDTH = BYTE_BITS                     // bits kept
)
(
  input  wire logic             sclClk,               // bus clock from master
  input  wire logic             rstn,                 // async reset, low
  input  wire logic             sdaIn,                // data line level
  output logic      [WIDTH-1:0] shiftOut              // last bits, msb first
);

  logic [WIDTH-1:0] shift_reg;                         // captured bits
  logic [WIDTH-1:0] shift_next;

  // shift in one bit per rising bus clock, msb arrives first
  always_comb
  begin
    shift_next = {shift_reg[WIDTH-2:0], sdaIn};
  end

  // the word is stable for a whole bit time, so the system side can take it
  // once it has seen the synchronised rising edge
  always_ff @(posedge sclClk or negedge rstn)
  begin
    if (!rstn)
      shift_reg <= '0;
    else
      shift_reg <= shift_next;
  end

  assign shiftOut = shift_reg;

endmodule // link_bit_capture

// ==== amp_serial_control_slave.sv ====
module amp_serial_control_slave
  import amp_ctrl_pkg::*;
(
  input  wire logic sys_clk,                // system clock, 250 MHz
  input  wire logic rstn,                   // async reset, active low
  input  wire logic sclClk,                 // bus clock from master
  input  wire logic sdaIn,                  // data line level
  output logic      sdaOut,                 // data drive level, always low
  output logic      sdaOe,                  // high while pulling data low
  input  wire logic addressSelectPin,       // address strap pin
  input  wire logic interfaceSelect,        // low two-wire, high other port
  input  wire logic beepDetect,             // beep present on beep input
  input  wire logic headphoneDetectInput,   // headphone plugged in
  output logic      headphoneOutputControl, // stored headphone control bit
  output logic      gainExternal,           // 1 external gain
  output logic      volumeAdjustable,       // 1 adjustable, 0 fixed 0 dB
  output logic      muteRequest,            // stored mute bit
  output logic      deviceActive,           // 1 active, 0 shutdown
  output logic      bridgedOutput,          // bridged stage in use
  output logic      speakerMuted            // effective mute after beep
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [SYNC_BITS-1:0] pinRaw;              // raw asynchronous pins
  logic [SYNC_BITS-1:0] pinMeta_reg;         // first stage, read by second only
  logic [SYNC_BITS-1:0] pinSync_reg;         // safe copies
  logic [SYNC_BITS-1:0] pinMeta_next;
  logic [SYNC_BITS-1:0] pinSync_next;
  logic                 sclDly_reg;          // previous synced clock
  logic                 sdaDly_reg;          // previous synced data
  logic                 sclDly_next;
  logic                 sdaDly_next;

  assign pinRaw = {sclClk, sdaIn, addressSelectPin, interfaceSelect,
                   beepDetect, headphoneDetectInput};

  // two flops per pin, plus one history stage for edge detection
  always_comb
  begin
    pinMeta_next = pinRaw;
    pinSync_next = pinMeta_reg;
    sclDly_next  = pinSync_reg[SYNC_SCL];
    sdaDly_next  = pinSync_reg[SYNC_SDA];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pinMeta_reg <= {SYNC_BITS{1'b1}};      // bus lines idle high
      pinSync_reg <= {SYNC_BITS{1'b1}};
      sclDly_reg  <= 1'b1;
      sdaDly_reg  <= 1'b1;
    end
    else
    begin
      pinMeta_reg <= pinMeta_next;
      pinSync_reg <= pinSync_next;
      sclDly_reg  <= sclDly_next;
      sdaDly_reg  <= sdaDly_next;
    end
  end

  // --------------------------------------------------------------------------
  // bus events
  // --------------------------------------------------------------------------
  logic sclSync;                             // synced clock level
  logic sdaSync;                             // synced data level
  logic sclRise;                             // clock went high
  logic sclFall;                             // clock went low
  logic startEv;                             // start condition seen
  logic stopEv;                              // stop condition seen
  logic addrSel;                             // synced address strap
  logic spiSel;                              // other port selected
  logic beepSync;                            // synced beep
  logic hpDetSync;                           // synced headphone detect
  logic [7:0] linkByte;                      // bits from the bus clock side

  assign sclSync   = pinSync_reg[SYNC_SCL];
  assign sdaSync   = pinSync_reg[SYNC_SDA];
  assign addrSel   = pinSync_reg[SYNC_ADDR_SEL];
  assign spiSel    = pinSync_reg[SYNC_IF_SEL];
  assign beepSync  = pinSync_reg[SYNC_BEEP];
  assign hpDetSync = pinSync_reg[SYNC_HP_DET];
  assign sclRise   = sclSync && !sclDly_reg;
  assign sclFall   = !sclSync && sclDly_reg;
  // data edges only count while the clock has been high for two samples,
  // so a data change just after a falling clock is not taken as an edge
  assign startEv   = sclSync && sclDly_reg && sdaDly_reg && !sdaSync;
  assign stopEv    = sclSync && sclDly_reg && !sdaDly_reg && sdaSync;

  // bits are taken in the bus clock's own domain on its rising edge
  link_bit_capture #(
    .WIDTH    (BYTE_BITS)
  ) u_capture (
    .sclClk   (sclClk),
    .rstn     (rstn),
    .sdaIn    (sdaIn),
    .shiftOut (linkByte)
  );

  // --------------------------------------------------------------------------
  // transfer sequencing
  // --------------------------------------------------------------------------
  link_state_t state_reg;                    // where in the transfer we are
  link_state_t state_next;
  logic [3:0]  bitCount_reg;                 // bits seen in current byte
  logic [3:0]  bitCount_next;
  logic        sdaOe_reg;                    // acknowledge drive
  logic        sdaOe_next;
  logic [7:0]  dataHold_reg;                 // last data byte received
  logic [7:0]  dataHold_next;
  logic        ackDone;                      // data acknowledge just ended

  // linkByte is read only after the synced rising edge, when the capture
  // register has been still for several system cycles
  always_comb
  begin
    state_next    = state_reg;
    bitCount_next = bitCount_reg;
    sdaOe_next    = sdaOe_reg;
    dataHold_next = dataHold_reg;
    ackDone       = 1'b0;
    if (spiSel)
    begin
      // other port selected: two-wire side stays silent
      state_next = ST_IDLE;
      sdaOe_next = 1'b0;
    end
    else if (startEv)
    begin
      // start or repeated start: begin address compare
      state_next    = ST_ADDR;
      bitCount_next = BIT_FIRST;
      sdaOe_next    = 1'b0;
    end
    else if (stopEv)
    begin
      // stop ends everything and frees the line
      state_next = ST_IDLE;
      sdaOe_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE, ST_IGNORE:
        begin
          // ignored bytes leave the line released until a start
          sdaOe_next = 1'b0;
        end
        ST_ADDR:
        begin
          if (sclRise)
          begin
            bitCount_next = 4'(bitCount_reg + 4'h1);
            if (bitCount_reg == BIT_LAST)
            begin
              bitCount_next = BIT_FIRST;
              if (linkByte == own_address(addrSel))
                state_next = ST_ADDR_ACK;
              else
                state_next = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK, ST_DATA_ACK:
        begin
          // first fall: pull low; second fall ends the ninth pulse
          if (sclFall)
          begin
            if (!sdaOe_reg)
              sdaOe_next = 1'b1;
            else
            begin
              sdaOe_next = 1'b0;
              state_next = ST_DATA;
              ackDone    = (state_reg == ST_DATA_ACK);
            end
          end
        end
        ST_DATA:
        begin
          if (sclRise)
          begin
            bitCount_next = 4'(bitCount_reg + 4'h1);
            if (bitCount_reg == BIT_LAST)
            begin
              bitCount_next = BIT_FIRST;
              dataHold_next = linkByte;
              state_next    = ST_DATA_ACK;
            end
          end
        end
        default:
        begin
          // illegal code: fall back to idle
          state_next = ST_IDLE;
          sdaOe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg    <= ST_IDLE;
      bitCount_reg <= BIT_FIRST;
      sdaOe_reg    <= 1'b0;
      dataHold_reg <= 8'h00;
    end
    else
    begin
      state_reg    <= state_next;
      bitCount_reg <= bitCount_next;
      sdaOe_reg    <= sdaOe_next;
      dataHold_reg <= dataHold_next;
    end
  end

  assign sdaOe  = sdaOe_reg;
  assign sdaOut = 1'b0;                      // open drain: only pulls low

  // --------------------------------------------------------------------------
  // control bits and output routing
  // --------------------------------------------------------------------------
  logic [CTRL_BITS-1:0] ctrl_reg;            // stored mode bits
  logic [CTRL_BITS-1:0] ctrl_next;
  logic [CTRL_BITS-1:0] holdCtrl;            // mode field of held byte
  logic                 modeAccept;          // held byte goes to ctrl now
  logic                 bridged_reg;
  logic                 bridged_next;
  logic                 spkMute_reg;
  logic                 spkMute_next;

  assign holdCtrl   = dataHold_reg[CTRL_BITS-1:0];
  // volume bytes are acknowledged but not decoded here
  assign modeAccept = ackDone && is_mode_byte(dataHold_reg);

  // update only once the acknowledge pulse is over
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (modeAccept)
      ctrl_next = holdCtrl;
    // beep forces the bridged path, whatever mute and headphone say
    bridged_next = beepSync || (!hpDetSync && !ctrl_reg[HP_CTRL_BIT]);
    spkMute_next = ctrl_reg[MUTE_BIT] && !beepSync;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg    <= CTRL_RESET;
      bridged_reg <= 1'b0;
      spkMute_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      bridged_reg <= bridged_next;
      spkMute_reg <= spkMute_next;
    end
  end

  assign headphoneOutputControl = ctrl_reg[HP_CTRL_BIT];
  assign gainExternal           = ctrl_reg[GAIN_BIT];
  assign volumeAdjustable       = ctrl_reg[VOL_MODE_BIT];
  assign muteRequest            = ctrl_reg[MUTE_BIT];
  assign deviceActive           = ctrl_reg[ACTIVE_BIT];
  assign bridgedOutput          = bridged_reg;
  assign speakerMuted           = spkMute_reg;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  addr_match_a: assert property (
    (state_reg == ST_ADDR && sclRise && bitCount_reg == BIT_LAST && !spiSel
     && linkByte == own_address(addrSel)) |=> state_reg == ST_ADDR_ACK)
    else $error("matching address not acknowledged");

  addr_miss_a: assert property (
    (state_reg == ST_ADDR && sclRise && bitCount_reg == BIT_LAST && !spiSel
     && linkByte != own_address(addrSel)) |=> state_reg == ST_IGNORE ##0 !sdaOe_reg)
    else $error("foreign address not ignored");

  restart_a: assert property (
    (startEv && !spiSel) |=> state_reg == ST_ADDR && bitCount_reg == BIT_FIRST)
    else $error("start did not restart address phase");

  stop_idle_a: assert property (
    (stopEv && !startEv) |=> state_reg == ST_IDLE && !sdaOe_reg)
    else $error("stop did not return to idle");

  ack_start_a: assert property (
    $rose(sdaOe_reg) |-> $past(sclFall)
      && (state_reg == ST_ADDR_ACK || state_reg == ST_DATA_ACK))
    else $error("acknowledge drive began outside a falling clock");

  ack_hold_a: assert property (
    (sdaOe_reg && sclRise && !spiSel && !startEv && !stopEv) |=> sdaOe_reg)
    else $error("acknowledge released during clock high");

  data_ack_a: assert property (
    (state_reg == ST_DATA_ACK && sclFall && !sdaOe_reg && !spiSel)
      |=> sdaOe_reg ##0 state_reg == ST_DATA_ACK)
    else $error("data byte not acknowledged");

  more_bytes_a: assert property (
    ackDone |=> state_reg == ST_DATA && bitCount_reg == BIT_FIRST)
    else $error("not ready for next data byte");

  bit_count_a: assert property (
    (bitCount_reg != $past(bitCount_reg) && bitCount_reg != BIT_FIRST)
      |-> $past(sclRise))
    else $error("bit counted without rising clock");

  ctrl_apply_a: assert property (
    modeAccept |=> ctrl_reg == $past(holdCtrl))
    else $error("accepted mode byte not applied");

  ctrl_keep_a: assert property (
    (ctrl_reg != $past(ctrl_reg)) |-> $past(modeAccept))
    else $error("control bits changed without accepted byte");

  spi_quiet_a: assert property (
    spiSel |=> !sdaOe_reg && state_reg == ST_IDLE)
    else $error("two-wire side active while other port selected");

  beep_route_a: assert property (
    beepSync |=> bridgedOutput && !speakerMuted)
    else $error("beep not routed through bridged stage");

  addr_ack_c:  cover property (state_reg == ST_ADDR_ACK ##[1:1000] sdaOe_reg);
  mode_byte_c: cover property (modeAccept);
  ignore_c:    cover property (state_reg == ST_IGNORE ##[1:1000] startEv);
  beep_c:      cover property (beepSync && muteRequest);

endmodule // amp_serial_control_slave

// ==== link_master_model.sv ====
// ----------------------------------------------------------------------------
// two-wire bus master model, open drain on the data line
// ----------------------------------------------------------------------------
module link_master_model
(
  output logic      sclClk,  // bus clock, stands high between frames
  output logic      sdaLow,  // 1 pulls the data line low
  input  wire logic sdaLine  // resolved data line level
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int QTR  = 20;  // quarter of the 80 ns bus period
  localparam int HALF = 40;  // high phase, keeps the bus at 12.5 MHz

  // idle bus: clock high, data released to the pull-up
  initial
  begin
    sclClk = 1'h1;
    sdaLow = 1'h0;
  end

  // start, also usable as a repeated start from clock low
  task automatic startBit();
    sdaLow = 1'h0;
    #QTR;
    sclClk = 1'h1;
    #QTR;
    sdaLow = 1'h1;
    #QTR;
    sclClk = 1'h0;
    #QTR;
  endtask

  // one bit, data changes only while the clock is low
  task automatic sendBit(input logic b);
    sdaLow = !b;
    #QTR;
    sclClk = 1'h1;
    #HALF;
    sclClk = 1'h0;
    #QTR;
  endtask

  // byte msb first, then release and clock the acknowledge slot
  task automatic sendByte(input logic [7:0] v, output logic ack);
    int i;
    for (i = 7; i >= 0; i--)
    begin
      sendBit(v[i]);
    end
    sdaLow = 1'h0;
    #QTR;
    sclClk = 1'h1;
    #1;
    ack = !sdaLine;
    #(HALF - 2);
    // low at both ends of the high phase counts as held through it
    ack = ack & !sdaLine;
    #1;
    sclClk = 1'h0;
    #QTR;
    #HALF; // lets the control update land before the caller looks
  endtask

  // stop: data rises while the clock is high
  task automatic stopBit();
    sdaLow = 1'h1;
    #QTR;
    sclClk = 1'h1;
    #QTR;
    sdaLow = 1'h0;
    #HALF;
  endtask
endmodule // link_master_model

// ==== amp_serial_control_slave_tb.sv ====
// ----------------------------------------------------------------------------
// testbench for the amplifier serial control slave
// ----------------------------------------------------------------------------
module amp_serial_control_slave_tb
  import amp_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sys_clk;                 // system clock
  logic       rstn;                    // reset, active low
  logic       sclClk;                  // bus clock from the master model
  logic       sdaLow;                  // master pulls data low
  logic       sdaOut;                  // device drive value
  logic       sdaOe;                   // device pulls data low
  logic       sdaLine;                 // resolved data line
  logic       addressSelectPin;        // address strap
  logic       interfaceSelect;         // port select
  logic       beepDetect;              // beep present
  logic       headphoneDetectInput;    // headphone plugged
  logic       headphoneOutputControl;  // stored bit 4
  logic       gainExternal;            // stored bit 3
  logic       volumeAdjustable;        // stored bit 2
  logic       muteRequest;             // stored bit 1
  logic       deviceActive;            // stored bit 0
  logic       bridgedOutput;           // bridged stage in use
  logic       speakerMuted;            // effective mute
  logic [4:0] ctrlBits;                // control outputs as one field
  logic [4:0] pattern [6];             // mode byte payloads
  int         mismatches;              // failed comparisons
  int         checks;                  // comparisons made

  // pull-up wins unless someone pulls low
  assign sdaLine  = sdaOe ? sdaOut : !sdaLow;
  assign ctrlBits = {headphoneOutputControl, gainExternal, volumeAdjustable, muteRequest, deviceActive};

  amp_serial_control_slave amp_serial_control_slave_inst (
    .sys_clk                (sys_clk),
    .rstn                   (rstn),
    .sclClk                 (sclClk),
    .sdaIn                  (sdaLine),
    .sdaOut                 (sdaOut),
    .sdaOe                  (sdaOe),
    .addressSelectPin       (addressSelectPin),
    .interfaceSelect        (interfaceSelect),
    .beepDetect             (beepDetect),
    .headphoneDetectInput   (headphoneDetectInput),
    .headphoneOutputControl (headphoneOutputControl),
    .gainExternal           (gainExternal),
    .volumeAdjustable       (volumeAdjustable),
    .muteRequest            (muteRequest),
    .deviceActive           (deviceActive),
    .bridgedOutput          (bridgedOutput),
    .speakerMuted           (speakerMuted)
  );

  link_master_model link_master_model_inst (
    .sclClk  (sclClk),
    .sdaLow  (sdaLow),
    .sdaLine (sdaLine)
  );

  // ----------------------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  // whole run is about 21 us of bus traffic
  initial
  begin
    #200us;
    mismatches++;
    stop_test();
  end

  // ----------------------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------------------
  task automatic checkVal(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // strap and status pins, always just after a system edge
  task automatic setPins(input logic a, input logic s, input logic b, input logic h);
    @(posedge sys_clk);
    #1;
    addressSelectPin     = a;
    interfaceSelect      = s;
    beepDetect           = b;
    headphoneDetectInput = h;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic putByte(input logic [7:0] v, input logic expAck);
    logic ack;
    link_master_model_inst.sendByte(v, ack);
    checkVal("ack", {7'h0, ack}, {7'h0, expAck});
  endtask

  // start plus address; the caller stops at once on a missing ack
  task automatic openFrame(input logic [7:0] addr, input logic expAck);
    link_master_model_inst.startBit();
    putByte(addr, expAck);
  endtask

  task automatic writeMode(input logic [4:0] m);
    openFrame(8'hd8, 1'h1);
    putByte({3'h0, m}, 1'h1);
    link_master_model_inst.stopBit();
    checkVal("ctrl", {3'h0, ctrlBits}, {3'h0, m});
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    mismatches = 0;
    checks     = 0;
    rstn       = 1'h0;
    addressSelectPin = 1'h0;
    interfaceSelect  = 1'h0;
    beepDetect       = 1'h0;
    headphoneDetectInput = 1'h0;
    pattern = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h0b};
    repeat (4) @(posedge sys_clk);
    #1;
    rstn = 1'h1;
    repeat (6) @(posedge sys_clk);
    checkVal("reset ctrl", {3'h0, ctrlBits}, {3'h0, CTRL_RESET});
    checkVal("reset oe", {7'h0, sdaOe}, 8'h00);
    checkVal("drive level", {7'h0, sdaOut}, 8'h00);

    // many bytes in one frame, each applied after its ack
    openFrame(8'hd8, 1'h1);
    foreach (pattern[i])
    begin
      putByte({3'h0, pattern[i]}, 1'h1);
      checkVal("ctrl", {3'h0, ctrlBits}, {3'h0, pattern[i]});
    end
    // volume byte is acked but leaves the control bits alone
    putByte(8'h9f, 1'h1);
    checkVal("ctrl vol", {3'h0, ctrlBits}, 8'h0b);
    link_master_model_inst.stopBit();

    // other strap value, then a read address: both ignored
    openFrame(8'hda, 1'h0);
    link_master_model_inst.stopBit();
    openFrame(8'hd9, 1'h0);
    link_master_model_inst.stopBit();
    checkVal("ctrl ign", {3'h0, ctrlBits}, 8'h0b);

    // stop in mid-byte discards the partial byte
    openFrame(8'hd8, 1'h1);
    link_master_model_inst.sendBit(1'h0);
    link_master_model_inst.sendBit(1'h0);
    link_master_model_inst.sendBit(1'h0);
    link_master_model_inst.sendBit(1'h1);
    link_master_model_inst.stopBit();
    repeat (8) @(posedge sys_clk);
    checkVal("ctrl part", {3'h0, ctrlBits}, 8'h0b);

    // repeated start restarts address matching
    openFrame(8'hd8, 1'h1);
    openFrame(8'hd8, 1'h1);
    putByte(8'h03, 1'h1);
    link_master_model_inst.stopBit();
    checkVal("ctrl rs", {3'h0, ctrlBits}, 8'h03);

    // strap high moves the address
    setPins(1'h1, 1'h0, 1'h0, 1'h0);
    openFrame(8'hd8, 1'h0);
    link_master_model_inst.stopBit();
    openFrame(8'hda, 1'h1);
    putByte(8'h12, 1'h1);
    link_master_model_inst.stopBit();
    checkVal("ctrl sel", {3'h0, ctrlBits}, 8'h12);
    setPins(1'h0, 1'h0, 1'h0, 1'h0);

    // beep overrides mute and headphone choices
    for (int m = 0; m < 2; m++)
    begin
      writeMode(m ? 5'h02 : 5'h12);
      for (int k = 0; k < 4; k++)
      begin
        setPins(1'h0, 1'h0, k[1], k[0]);
        checkVal("bridged", {7'h0, bridgedOutput}, {7'h0, k[1] | (!k[0] & m[0])});
        checkVal("muted", {7'h0, speakerMuted}, {7'h0, !k[1]});
      end
    end

    // other port selected: two-wire side stays silent
    setPins(1'h0, 1'h1, 1'h0, 1'h0);
    openFrame(8'hd8, 1'h0);
    link_master_model_inst.stopBit();
    checkVal("ctrl spi", {3'h0, ctrlBits}, 8'h02);
    setPins(1'h0, 1'h0, 1'h0, 1'h0);

    // second reset in mid-run
    @(posedge sys_clk);
    #1;
    rstn = 1'h0;
    repeat (4) @(posedge sys_clk);
    checkVal("rst ctrl", {3'h0, ctrlBits}, 8'h00);
    #1;
    rstn = 1'h1;
    repeat (6) @(posedge sys_clk);
    writeMode(5'h1f);
    stop_test();
  end
endmodule // amp_serial_control_slave_tb
